// [rtl/dma_chain_sequencer.sv]
/*
 DMA sequencing for four channels: serial, SPI, parallel (chain capable)
 and input data port (no chaining). APB register slave, word transfer
 grants to peripherals, control block loads from internal memory.
 Assumes memory answers each read pulse with one memRdValid later.
*/
`timescale 1ns/1ps
`include "dma_chain_consts.svh"
module dma_chain_sequencer (
    input  wire logic                  clk_sys,     // System clock, 10 MHz
    input  wire logic                  reset,       // Synchronous reset, active high
    input  wire logic                  psel,        // APB select
    input  wire logic                  penable,     // APB enable
    input  wire logic                  pwrite,      // APB direction
    input  wire logic [`APB_AW-1:0]    paddr,       // APB byte address
    input  wire logic [31:0]           pwdata,      // APB write data
    output logic      [31:0]           prdata,      // APB read data
    output logic                       pready,      // APB ready
    output logic                       pslverr,     // APB error, unmapped address
    input  wire logic [`NUM_CH-1:0]    xferReq,     // Peripheral wants a word moved
    output logic      [`NUM_CH-1:0]    xferGrant,   // One-cycle word grant
    output logic      [`CP_W-1:0]      xferAddr,    // Memory address of granted word
    output logic                       memRdEn,     // Control block word read pulse
    output logic      [`CP_W-1:0]      memAddr,     // Control block word address
    input  wire logic                  memRdValid,  // Read data valid
    input  wire logic [31:0]           memRdData,   // Read data
    output logic      [`NUM_CH-1:0]    chanIrq,     // Interrupt pulse to core latch
    output logic      [`NUM_CH-1:0]    chanActive   // Channel running, from status
);
    dma_load_arb_if arbBus ();

    dma_chain_pkg::chState_t state_q [`NUM_CH];
    logic [`NUM_CH-1:0]      dmaEn_q;
    logic [`NUM_CH-1:0]      chainEn_q;
    logic [`ADDR_W-1:0]      index_q  [`NUM_CH];
    logic [`ADDR_W-1:0]      modif_q  [`NUM_CH];
    logic [`CNT_W-1:0]       count_q  [`NUM_CH];
    logic [`CP_W-1:0]        cp_q     [`NUM_CH];
    logic [31:0]             extIdx_q [`NUM_CH];
    logic [31:0]             extMod_q [`NUM_CH];
    logic [31:0]             extCnt_q [`NUM_CH];
    logic [1:0]              stat_q   [`NUM_CH];

    logic                    ldActive_q;
    dma_chain_pkg::chIdx_t   ldCh_q;
    logic [2:0]              ldWord_q;
    logic                    ldWrite;
    logic                    ldLast;
    logic                    xferGo;
    logic                    ldStart;
    logic                    apbWr;
    logic                    apbRdCapture;
    dma_chain_pkg::chIdx_t   regCh;
    logic [3:0]              regField;
    logic                    regMapped;
    logic [31:0]             rdMux;

    function automatic logic chainCapable(input dma_chain_pkg::chIdx_t ch);
        chainCapable = (ch != `CH_IDP);
    endfunction : chainCapable

    function automatic logic [2:0] tcbLast(input dma_chain_pkg::chIdx_t ch);
        tcbLast = (ch == `CH_PAR) ? `TCB_LONG_LAST : `TCB_SHORT_LAST;
    endfunction : tcbLast

    // APB decode: one wait state so every bus output is a flip-flop
    assign regCh        = paddr[7:6];
    assign regField     = paddr[5:2];
    assign regMapped    = (paddr[`APB_AW-1:8] == 4'h0) && (regField <= `REG_EXT_COUNT) && (paddr[1:0] == 2'h0);
    assign apbWr        = psel && penable && pready && pwrite && regMapped;
    assign apbRdCapture = psel && penable && !pready;

    always_comb begin
        rdMux = 32'h0;
        unique case (regField)
            `REG_CTRL:      rdMux = {30'h0, chainEn_q[regCh], dmaEn_q[regCh]};
            `REG_STATUS:    rdMux = {30'h0, stat_q[regCh]};
            `REG_INDEX:     rdMux = {13'h0, index_q[regCh]};
            `REG_MODIFIER:  rdMux = {13'h0, modif_q[regCh]};
            `REG_COUNT:     rdMux = {16'h0, count_q[regCh]};
            `REG_CHAINPTR:  rdMux = {12'h0, cp_q[regCh]};
            `REG_EXT_INDEX: rdMux = extIdx_q[regCh];
            `REG_EXT_MOD:   rdMux = extMod_q[regCh];
            `REG_EXT_COUNT: rdMux = extCnt_q[regCh];
            default:        rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbRdCapture;
            pslverr <= apbRdCapture && !regMapped;
            if (apbRdCapture) begin
                prdata <= regMapped ? rdMux : 32'h0;
            end
        end
    end

    // Arbiter hookup
    assign xferGo  = arbBus.gntValid && !arbBus.gntLoad;
    assign ldStart = arbBus.gntValid && arbBus.gntLoad;
    assign ldWrite = ldActive_q && memRdValid;
    assign ldLast  = (ldWord_q == tcbLast(ldCh_q));
    assign arbBus.done = ldWrite && ldLast;

    dma_load_arbiter u_arb (
        .clk_sys (clk_sys),
        .reset   (reset),
        .arb     (arbBus.arb)
    );

    // Control block fetch engine, one word outstanding at a time
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ldActive_q <= 1'b0;
            ldCh_q     <= 2'h0;
            ldWord_q   <= 3'h0;
            memRdEn    <= 1'b0;
            memAddr    <= `CP_W'h0;
        end else begin
            memRdEn <= 1'b0;
            if (ldStart) begin
                ldActive_q <= 1'b1;
                ldCh_q     <= arbBus.gntCh;
                ldWord_q   <= 3'h0;
                memRdEn    <= 1'b1;
                memAddr    <= `MEM_BASE + {1'b0, cp_q[arbBus.gntCh][`ADDR_W-1:0]};
            end else if (ldWrite) begin
                if (ldLast) begin
                    ldActive_q <= 1'b0;
                end else begin
                    ldWord_q <= ldWord_q + 3'h1;
                    memRdEn  <= 1'b1;
                    memAddr  <= memAddr - `CP_W'h1;
                end
            end
        end
    end

    // Word grant to the peripheral with its address
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            xferGrant <= '0;
            xferAddr  <= `CP_W'h0;
        end else begin
            xferGrant <= '0;
            if (xferGo) begin
                xferGrant[arbBus.gntCh] <= 1'b1;
                xferAddr                <= `MEM_BASE + {1'b0, index_q[arbBus.gntCh]};
            end
        end
    end

    for (genvar g = 0; g < `NUM_CH; g++) begin : g_ch
        logic selWr;
        logic ctrlWr;
        logic cpWr;
        logic newDma;
        logic newChain;
        logic myXfer;
        logic myLoad;

        assign selWr    = apbWr && (regCh == 2'(g));
        assign ctrlWr   = selWr && (regField == `REG_CTRL);
        assign cpWr     = selWr && (regField == `REG_CHAINPTR);
        assign newDma   = pwdata[`CTRL_DMA_EN];
        assign newChain = pwdata[`CTRL_CHAIN_EN] && chainCapable(2'(g));
        assign myXfer   = xferGo && (arbBus.gntCh == 2'(g));
        assign myLoad   = ldWrite && (ldCh_q == 2'(g));

        // Insertion mode keeps transfers going with the enable cleared
        assign arbBus.req[g] = (state_q[g] == dma_chain_pkg::CH_LDWAIT)
            || ((state_q[g] == dma_chain_pkg::CH_RUN) && (dmaEn_q[g] || chainEn_q[g])
                && xferReq[g] && !xferGrant[g]);
        assign arbBus.loadReq[g] = (state_q[g] == dma_chain_pkg::CH_LDWAIT);

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                stat_q[g]     <= 2'h0;
                chanActive[g] <= 1'b0;
            end else begin
                // Loading reads as inactive
                stat_q[g][`STAT_ACTIVE]  <= (state_q[g] == dma_chain_pkg::CH_RUN);
                stat_q[g][`STAT_LOADING] <= (state_q[g] == dma_chain_pkg::CH_LDWAIT)
                                         || (state_q[g] == dma_chain_pkg::CH_LOADING);
                chanActive[g]            <= (state_q[g] == dma_chain_pkg::CH_RUN);
            end
        end

        always_ff @(posedge clk_sys) begin
            if (reset) begin
                state_q[g]   <= dma_chain_pkg::CH_IDLE;
                dmaEn_q[g]   <= 1'b0;
                chainEn_q[g] <= 1'b0;
                index_q[g]   <= '0;
                modif_q[g]   <= '0;
                count_q[g]   <= '0;
                cp_q[g]      <= '0;
                extIdx_q[g]  <= 32'h0;
                extMod_q[g]  <= 32'h0;
                extCnt_q[g]  <= 32'h0;
                chanIrq[g]   <= 1'b0;
            end else begin
                chanIrq[g] <= 1'b0;
                // Software writes first; hardware updates below override them
                if (ctrlWr) begin
                    dmaEn_q[g]   <= newDma;
                    chainEn_q[g] <= newChain;
                end
                if (selWr) begin
                    unique case (regField)
                        `REG_INDEX:     index_q[g] <= pwdata[`ADDR_W-1:0];
                        `REG_MODIFIER:  modif_q[g] <= pwdata[`ADDR_W-1:0];
                        `REG_COUNT:     count_q[g] <= pwdata[`CNT_W-1:0]; // no interrupt
                        `REG_CHAINPTR:  cp_q[g]    <= pwdata[`CP_W-1:0]; // any time
                        `REG_EXT_INDEX: extIdx_q[g] <= (2'(g) == `CH_PAR) ? pwdata : 32'h0;
                        `REG_EXT_MOD:   extMod_q[g] <= (2'(g) == `CH_PAR) ? pwdata : 32'h0;
                        `REG_EXT_COUNT: extCnt_q[g] <= (2'(g) == `CH_PAR) ? pwdata : 32'h0;
                        default: ;
                    endcase
                end
                unique case (state_q[g])
                    dma_chain_pkg::CH_IDLE: begin
                        if (ctrlWr && !newChain && newDma && !dmaEn_q[g]) begin
                            state_q[g] <= dma_chain_pkg::CH_RUN;
                        end else if (cpWr && chainEn_q[g] && dmaEn_q[g]
                                     && (pwdata[`ADDR_W-1:0] != '0)) begin
                            state_q[g] <= dma_chain_pkg::CH_LDWAIT;
                        end
                    end
                    dma_chain_pkg::CH_RUN: begin
                        if (ctrlWr && !newDma && !newChain) begin
                            state_q[g] <= dma_chain_pkg::CH_IDLE;
                        end else if (myXfer) begin
                            index_q[g] <= index_q[g] + modif_q[g];
                            count_q[g] <= count_q[g] - `CNT_W'h1;
                            if (count_q[g] == `CNT_W'h1) begin
                                if (chainEn_q[g] && !dmaEn_q[g]) begin
                                    chanIrq[g] <= 1'b1;
                                    state_q[g] <= dma_chain_pkg::CH_IDLE;
                                end else if (chainEn_q[g] && (cp_q[g][`ADDR_W-1:0] != '0)) begin
                                    // Self-pointing blocks simply reload
                                    chanIrq[g] <= cp_q[g][`CP_INTSEL_BIT];
                                    state_q[g] <= dma_chain_pkg::CH_LDWAIT;
                                end else begin
                                    chanIrq[g] <= 1'b1;
                                    state_q[g] <= dma_chain_pkg::CH_IDLE;
                                end
                            end
                        end
                    end
                    dma_chain_pkg::CH_LDWAIT: begin
                        if (ldStart && (arbBus.gntCh == 2'(g))) begin
                            state_q[g] <= dma_chain_pkg::CH_LOADING;
                        end
                    end
                    dma_chain_pkg::CH_LOADING: begin
                        if (myLoad) begin
                            unique case (ldWord_q)
                                3'h0: index_q[g]  <= memRdData[`ADDR_W-1:0];
                                3'h1: modif_q[g]  <= memRdData[`ADDR_W-1:0];
                                3'h2: count_q[g]  <= memRdData[`CNT_W-1:0];
                                3'h3: cp_q[g]     <= memRdData[`CP_W-1:0];
                                3'h4: extIdx_q[g] <= memRdData;
                                3'h5: extMod_q[g] <= memRdData;
                                default: extCnt_q[g] <= memRdData;
                            endcase
                            if (ldLast) begin
                                state_q[g] <= dma_chain_pkg::CH_RUN;
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule : dma_chain_sequencer

// [rtl/dma_chain_consts.svh]
/*
 Constants of the DMA chain sequencer: channel map, register offsets,
 field positions and control block layout.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DMA_CHAIN_CONSTS_SVH
`define DMA_CHAIN_CONSTS_SVH

`define NUM_CH        4
`define CH_SERIAL     2'h0
`define CH_SPI        2'h1
`define CH_PAR        2'h2
`define CH_IDP        2'h3

`define ADDR_W        19
`define CP_W          20
`define CNT_W         16
`define CP_INTSEL_BIT 19
`define MEM_BASE      20'h80000
`define TCB_SHORT_LAST 3'h3
`define TCB_LONG_LAST  3'h6

`define APB_AW        12
`define REG_CTRL      4'h0
`define REG_STATUS    4'h1
`define REG_INDEX     4'h2
`define REG_MODIFIER  4'h3
`define REG_COUNT     4'h4
`define REG_CHAINPTR  4'h5
`define REG_EXT_INDEX 4'h6
`define REG_EXT_MOD   4'h7
`define REG_EXT_COUNT 4'h8

`define CTRL_DMA_EN   0
`define CTRL_CHAIN_EN 1
`define STAT_ACTIVE   0
`define STAT_LOADING  1

`endif

// [rtl/dma_chain_pkg.sv]
/*
 Types shared by the chain sequencer and its load arbiter.
 Assumes dma_chain_consts.svh is compiled alongside.
*/
package dma_chain_pkg;
    typedef logic [1:0] chIdx_t;
    typedef enum logic [1:0] {
        CH_IDLE    = 2'h0,
        CH_LDWAIT  = 2'h1,
        CH_LOADING = 2'h3,
        CH_RUN     = 2'h2
    } chState_t;
endpackage : dma_chain_pkg

// [rtl/dma_load_arb_if.sv]
/*
 Request and grant bundle between the sequencer and the load arbiter.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`include "dma_chain_consts.svh"
interface dma_load_arb_if;
    logic [`NUM_CH-1:0]    req;       // Any request per channel
    logic [`NUM_CH-1:0]    loadReq;   // Control block load requests
    logic                  done;      // Control block load finished
    logic                  gntValid;  // One-cycle grant
    logic                  gntLoad;   // Grant is for a load
    dma_chain_pkg::chIdx_t gntCh;     // Granted channel

    modport seq (output req, loadReq, done, input gntValid, gntLoad, gntCh);
    modport arb (input req, loadReq, done, output gntValid, gntLoad, gntCh);
endinterface : dma_load_arb_if

// [rtl/dma_load_arbiter.sv]
/*
 Fixed-priority arbiter, channel 0 highest. A granted load holds the
 arbiter locked until the sequencer reports the load done.
 Assumes the requester masks a word request once granted.
*/
`timescale 1ns/1ps
`include "dma_chain_consts.svh"
module dma_load_arbiter (
    input  wire logic     clk_sys,  // System clock
    input  wire logic     reset,    // Synchronous reset, active high
    dma_load_arb_if.arb   arb       // Requests in, grants out
);
    logic busy_q;

    function automatic dma_chain_pkg::chIdx_t pickHighest(input logic [`NUM_CH-1:0] r);
        pickHighest = 2'h0;
        for (int i = `NUM_CH - 1; i >= 0; i--) begin
            if (r[i]) begin
                pickHighest = 2'(i);
            end
        end
    endfunction : pickHighest

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            arb.gntValid <= 1'b0;
            arb.gntLoad  <= 1'b0;
            arb.gntCh    <= 2'h0;
            busy_q       <= 1'b0;
        end else begin
            arb.gntValid <= 1'b0;
            if (arb.done) begin
                busy_q <= 1'b0;
            end
            // Locked while a load runs: no pre-emption
            if (!busy_q && !arb.gntValid && |arb.req) begin
                arb.gntValid <= 1'b1;
                arb.gntCh    <= pickHighest(arb.req);
                arb.gntLoad  <= arb.loadReq[pickHighest(arb.req)];
                busy_q       <= arb.loadReq[pickHighest(arb.req)];
            end
        end
    end
endmodule : dma_load_arbiter

// [bench/dma_chain_sequencer_checker.sv]
/* Port assertions for the chain sequencer.
   Assumes the constants header and the bind at the foot. */
`timescale 1ns/1ps
`include "dma_chain_consts.svh"
module dma_chain_sequencer_checker (
    input wire logic               clk_sys,    // Clock
    input wire logic               reset,      // Reset
    input wire logic               psel,       // APB select
    input wire logic               penable,    // APB enable
    input wire logic               pready,     // APB ready
    input wire logic               pslverr,    // APB error
    input wire logic [`NUM_CH-1:0] xferReq,    // Word requests
    input wire logic [`NUM_CH-1:0] xferGrant,  // Word grants
    input wire logic [`CP_W-1:0]   xferAddr,   // Word address
    input wire logic               memRdEn,    // Block read
    input wire logic [`CP_W-1:0]   memAddr,    // Block address
    input wire logic [`NUM_CH-1:0] chanIrq,    // Interrupts
    input wire logic [`NUM_CH-1:0] chanActive  // Running
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_apb_wait_state: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not on second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_grant_gap: assert property (|xferGrant |=> xferGrant == '0)
        else $error("grants on adjacent cycles");
    chk_grant_cause: assert property (|xferGrant |-> (xferGrant & ~$past(xferReq, 2)) == '0)
        else $error("grant without request");
    chk_grant_single: assert property ($onehot0(xferGrant))
        else $error("grant to several channels");
    chk_word_base: assert property (|xferGrant |-> xferAddr >= `MEM_BASE)
        else $error("word address below memory base");
    chk_load_base: assert property (memRdEn |-> memAddr >= `MEM_BASE)
        else $error("block address below memory base");
    chk_load_locked: assert property (memRdEn |=> (xferGrant == '0 && !memRdEn) [*2])
        else $error("grant during block load");
    chk_irq_cause: assert property (|chanIrq |->
        (chanIrq & ~(xferGrant | $past(xferGrant) | $past(xferGrant, 2))) == '0)
        else $error("interrupt without a transfer");
    chk_grant_running: assert property ((xferGrant & ~chanActive) == '0)
        else $error("grant to a channel not running");
    chk_reset_quiet: assert property ($fell(reset) |-> xferGrant == '0 && chanIrq == '0 && !memRdEn)
        else $error("outputs busy after reset");
    cover property (memRdEn ##[1:8] memRdEn);
    cover property (|chanIrq);
    cover property (pslverr);
endmodule : dma_chain_sequencer_checker

bind dma_chain_sequencer dma_chain_sequencer_checker dma_chain_sequencer_checker_i (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .xferReq(xferReq), .xferGrant(xferGrant), .xferAddr(xferAddr),
    .memRdEn(memRdEn), .memAddr(memAddr), .chanIrq(chanIrq), .chanActive(chanActive));

// [bench/dma_mem_model.sv]
/* Internal memory for control block loads, answering a read in one or
   four cycles. Assumes the bench fills mem by hierarchical reference. */
`timescale 1ns/1ps
module dma_mem_model (
    input  wire logic        clk_sys,     // System clock
    input  wire logic        reset,       // Synchronous reset
    input  wire logic        slow,        // Stretch the answer
    input  wire logic        memRdEn,     // Read pulse
    input  wire logic [19:0] memAddr,     // Word address
    output logic             memRdValid,  // Answer pulse
    output logic      [31:0] memRdData    // Answer data
);
    logic [31:0] mem [logic [19:0]];
    logic [19:0] addr_q;
    int          wait_q = 0;
    initial begin
        memRdValid = 1'b0;
        memRdData  = 32'h0;
    end
    // Data flips outside an answer so a late sample cannot look right
    always @(posedge clk_sys) begin
        memRdValid <= 1'b0;
        memRdData  <= ~memRdData;
        if (reset) wait_q <= 0;
        else if (memRdEn) begin
            addr_q <= memAddr;
            wait_q <= slow ? 4 : 1;
        end else if (wait_q == 1) begin
            memRdValid <= 1'b1;
            memRdData  <= mem.exists(addr_q) ? mem[addr_q] : 32'h0;
            wait_q     <= 0;
        end else if (wait_q > 1) wait_q <= wait_q - 1;
    end
endmodule : dma_mem_model

// [bench/test_dma_chain_sequencer.sv]
/* Self-checking bench: APB master, peripheral word requests, memory model.
   Assumes the rtl files and the bench files are compiled together. */
`timescale 1ns/1ps
`include "dma_chain_consts.svh"
module test_dma_chain_sequencer;
    logic        clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, memRdData, rdat;
    logic [3:0]  xferReq = '0, xferGrant, chanIrq, chanActive;
    logic [19:0] xferAddr, memAddr, idx, mdf, p1 = 20'h00100, p2 = 20'h00200;
    logic        pready, pslverr, memRdEn, memRdValid, slow = 1'b0, rerr;
    logic [24:0] notes[$];
    int          bad_count = 0, n_tests = 0, loads = 0, seed = 32'hd553f584;
    always #50 clk_sys = ~clk_sys;
    dma_chain_sequencer dma_chain_sequencer_i (.clk_sys(clk_sys), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xferReq(xferReq), .xferGrant(xferGrant),
        .xferAddr(xferAddr), .memRdEn(memRdEn), .memAddr(memAddr), .memRdValid(memRdValid),
        .memRdData(memRdData), .chanIrq(chanIrq), .chanActive(chanActive));
    dma_mem_model dma_mem_model_i (.clk_sys(clk_sys), .reset(reset), .slow(slow), .memRdEn(memRdEn),
        .memAddr(memAddr), .memRdValid(memRdValid), .memRdData(memRdData));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    function automatic logic [11:0] ra(input logic [1:0] ch, input logic [3:0] f);
        return {4'h0, ch, f, 2'b00};
    endfunction : ra
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        if (n >= 50) bad_count++;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rdat, exp);
    endtask : rchk
    // Notes go in before the request so the monitor never sees an empty queue
    task automatic xfer(input int ch, input logic [19:0] a, input logic irq);
        int n;
        n = 0;
        notes.push_back({1'b0, 4'b0001 << ch, a});
        if (irq) notes.push_back({1'b1, 4'b0001 << ch, 20'h0});
        xferReq[ch] <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (xferGrant[ch] !== 1'b1 && n < 200);
        xferReq[ch] <= 1'b0;
        if (n >= 200) bad_count++;
        repeat (1 + ($random(seed) & 3)) @(posedge clk_sys);
    endtask : xfer
    task automatic put(input logic [19:0] p, input logic [31:0] w0, w1, w2, w3);
        dma_mem_model_i.mem[`MEM_BASE + p] = w0;
        dma_mem_model_i.mem[`MEM_BASE + p - 20'h1] = w1;
        dma_mem_model_i.mem[`MEM_BASE + p - 20'h2] = w2;
        dma_mem_model_i.mem[`MEM_BASE + p - 20'h3] = w3;
    endtask : put
    task automatic take(input logic [24:0] seen);
        check("event", {7'h0, seen}, (notes.size() > 0) ? {7'h0, notes.pop_front()} : 32'hffffffff);
    endtask : take
    always @(posedge clk_sys) begin
        if (memRdEn === 1'b1) loads++;
        if (!reset && |xferGrant) take({1'b0, xferGrant, xferAddr});
        if (!reset && |chanIrq) take({1'b1, chanIrq, 20'h0});
    end
    task automatic complete_run;
        $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        #(20000 * 100);
        bad_count++;
        complete_run();
    end
    initial begin
        int n;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int c = 0; c < 4; c++) rchk("ctrl reset", ra(c[1:0], `REG_CTRL), 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        check("unmapped error", {31'h0, rerr}, 32'h1);
        check("unmapped data", rdat, 32'h0);
        $display("Test registers done");
        for (int c = 0; c < 4; c++) begin
            idx = 20'($random(seed) & 32'hfff0);
            mdf = 20'(1 + ($random(seed) & 7));
            apb(1'b1, ra(c[1:0], `REG_INDEX), {12'h0, idx});
            apb(1'b1, ra(c[1:0], `REG_MODIFIER), {12'h0, mdf});
            apb(1'b1, ra(c[1:0], `REG_COUNT), 32'h2);
            apb(1'b1, ra(c[1:0], `REG_CTRL), 32'h1);
            rchk("status run", ra(c[1:0], `REG_STATUS), 32'h1);
            xfer(c, `MEM_BASE + idx, 1'b0);
            xfer(c, `MEM_BASE + idx + mdf, 1'b1);
            rchk("index", ra(c[1:0], `REG_INDEX), {12'h0, idx + 2 * mdf});
            rchk("status end", ra(c[1:0], `REG_STATUS), 32'h0);
            apb(1'b1, ra(c[1:0], `REG_CTRL), 32'h0);
        end
        apb(1'b1, ra(2'h3, `REG_COUNT), 32'h0);
        apb(1'b1, ra(2'h3, `REG_CTRL), 32'h3);
        rchk("no chain bit", ra(2'h3, `REG_CTRL), 32'h1);
        repeat (6) @(posedge clk_sys);
        apb(1'b1, ra(2'h3, `REG_CTRL), 32'h0);
        rchk("stopped", ra(2'h3, `REG_STATUS), 32'h0);
        $display("Test unchained done");
        slow <= 1'b1;
        put(p1, {12'h0, idx}, {12'h0, mdf}, 32'h2, {12'h0, 1'b1, p2[18:0]});
        put(p2, {12'h0, idx + 20'h40}, {12'h0, mdf}, 32'h1, 32'h0);
        apb(1'b1, ra(2'h0, `REG_CTRL), 32'h3);
        apb(1'b1, ra(2'h0, `REG_CHAINPTR), {12'h0, 1'b1, p1[18:0]});
        xfer(0, `MEM_BASE + idx, 1'b0);
        xfer(0, `MEM_BASE + idx + mdf, 1'b1);
        xfer(0, `MEM_BASE + idx + 20'h40, 1'b1);
        rchk("last pointer", ra(2'h0, `REG_CHAINPTR), 32'h0);
        rchk("chain end", ra(2'h0, `REG_STATUS), 32'h0);
        apb(1'b1, ra(2'h0, `REG_CTRL), 32'h0);
        $display("Test chained done");
        slow <= 1'b0;
        put(p1, {12'h0, idx}, {12'h0, mdf}, 32'h1, {12'h0, 1'b0, p1[18:0]});
        dma_mem_model_i.mem[`MEM_BASE + p1 - 20'h5] = 32'h00055;
        apb(1'b1, ra(2'h2, `REG_CTRL), 32'h3);
        apb(1'b1, ra(2'h2, `REG_CHAINPTR), {12'h0, p1});
        xfer(2, `MEM_BASE + idx, 1'b0);
        xfer(2, `MEM_BASE + idx, 1'b0);
        n = 0;
        while (chanActive[2] !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        rchk("ext modifier", ra(2'h2, `REG_EXT_MOD), 32'h00055);
        n = loads;
        apb(1'b1, ra(2'h2, `REG_CTRL), 32'h2);
        xfer(2, `MEM_BASE + idx, 1'b1);
        repeat (8) @(posedge clk_sys);
        check("insert loads", loads - n, 32'h0);
        rchk("insert end", ra(2'h2, `REG_STATUS), 32'h0);
        $display("Test parallel done");
        check("pending", notes.size(), 32'h0);
        complete_run();
    end
endmodule : test_dma_chain_sequencer
